// >>> rpsw_event_flag.sv
`timescale 1ns/10ps
module rpsw_event_flag
  import rpsw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // event and clear
  input wire logic set_in,
  input wire logic clear_in,
  // flag
  output logic flag_out
);
  logic flag_reg;
  logic flag_next;

  // set beats a clear in the same cycle
  assign flag_next = set_in | (flag_reg & ~clear_in);

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;

  set_keeps_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    set_in |=> flag_reg)
    else $error("flag lost an event that arrived with its clear");
endmodule

// >>> rpsw_pkg.sv
package rpsw_pkg;
  // register offsets
  localparam logic [7:0] RPSW_PORT_SEL_ADDR = 8'h4C;
  localparam logic [7:0] RPSW_STATUS_A_ADDR = 8'h4D;
  localparam logic [7:0] RPSW_STATUS_B_ADDR = 8'h4E;
  localparam logic [7:0] RPSW_PAR_HI_ADDR = 8'h55;
  localparam logic [7:0] RPSW_PAR_LO_ADDR = 8'h56;
  // port select register fields
  localparam int RPSW_PHYS_PORT_BIT = 6;
  localparam int RPSW_READ_PORT_BIT = 4;
  localparam int RPSW_WEN1_BIT = 1;
  localparam int RPSW_WEN0_BIT = 0;
  // status register fields
  localparam int RPSW_ST_PORT_BIT = 6;
  localparam int RPSW_ST_CRC_BIT = 5;
  localparam int RPSW_ST_LCHG_BIT = 4;
  localparam int RPSW_ST_SEQ_BIT = 3;
  localparam int RPSW_ST_PAR_BIT = 2;
  localparam int RPSW_ST_PASS_BIT = 1;
  localparam int RPSW_ST_LOCK_BIT = 0;
  // reset values and parity counter limit
  localparam logic [1:0] RPSW_WEN_RESET = 2'h0;
  localparam logic RPSW_READ_PORT_RESET = 1'b0;
  localparam logic [7:0] RPSW_DATA_RESET = 8'h00;
  localparam logic [15:0] RPSW_PAR_CNT_RESET = 16'h0000;
  localparam logic [15:0] RPSW_PAR_CNT_MAX = 16'hFFFF;
  // access source encoding
  typedef enum logic [1:0] {
    RPSW_SRC_LOCAL,
    RPSW_SRC_REMOTE0,
    RPSW_SRC_REMOTE1
  } rpsw_src_t;
endpackage

// >>> rpsw_reg_bank.sv
`timescale 1ns/10ps
module rpsw_reg_bank
  import rpsw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // register access from serial control slave
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic src_remote_in,
  input wire logic src_port_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // paged receiver register write steering and read port select
  output logic [1:0] page_wr_en_out,
  output logic [7:0] page_addr_out,
  output logic [7:0] page_data_out,
  output logic read_port_out,
  // receiver port status
  input wire logic [1:0] lock_in,
  input wire logic [1:0] pass_in,
  input wire logic [1:0] crc_err_in,
  input wire logic [1:0] seq_err_in,
  input wire logic [1:0] parity_err_in,
  input wire logic [15:0] parity_limit_setting_in
);
  rpsw_src_t src_reg;
  rpsw_src_t src_now;
  logic [1:0] wen_reg;
  logic [1:0] wen_next;
  logic read_port_reg;
  logic read_port_next;
  logic [1:0] lock_prev_reg;
  logic [15:0] par_cnt_reg [2];
  logic [15:0] par_cnt_next [2];
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic rd_valid_reg;
  logic [1:0] page_wr_en_reg;
  logic [1:0] page_wr_en_next;
  logic [7:0] page_addr_reg;
  logic [7:0] page_data_reg;

  wire access = reg_wr_in | reg_rd_in;
  wire src_switch = access && (src_now != src_reg);
  wire [1:0] wen_default = (src_now == RPSW_SRC_REMOTE1) ? 2'h2 :
                           (src_now == RPSW_SRC_REMOTE0) ? 2'h1 : RPSW_WEN_RESET;
  wire read_port_default = (src_now == RPSW_SRC_REMOTE1);
  wire [1:0] wen_cur = src_switch ? wen_default : wen_reg;
  wire read_port_cur = src_switch ? read_port_default : read_port_reg;
  wire phys_port = (src_now == RPSW_SRC_REMOTE1);
  wire sel_wr = reg_wr_in && (reg_addr_in == RPSW_PORT_SEL_ADDR);
  wire page_wr = reg_wr_in && (reg_addr_in != RPSW_PORT_SEL_ADDR);
  wire sts_rd = reg_rd_in && (reg_addr_in == RPSW_STATUS_A_ADDR);
  wire par_lo_rd = reg_rd_in && (reg_addr_in == RPSW_PAR_LO_ADDR);
  wire [1:0] rd_port_mask = read_port_cur ? 2'h2 : 2'h1;
  wire [1:0] sts_clear = sts_rd ? rd_port_mask : 2'h0;
  wire [1:0] lock_valid_rise = lock_in & ~lock_prev_reg;
  wire [1:0] lock_change = lock_in ^ lock_prev_reg;
  wire [1:0] par_clear = (par_lo_rd ? rd_port_mask : 2'h0) | lock_valid_rise;
  wire [1:0] crc_flag;
  wire [1:0] seq_flag;
  wire [1:0] lchg_flag;
  wire [1:0] par_flag;
  wire [1:0] par_over;

  assign src_now = !src_remote_in ? RPSW_SRC_LOCAL :
                   (src_port_in ? RPSW_SRC_REMOTE1 : RPSW_SRC_REMOTE0);

  // port select register update, write on top of source defaults
  assign wen_next = sel_wr ? reg_wdata_in[RPSW_WEN1_BIT:RPSW_WEN0_BIT] : wen_cur;
  assign read_port_next = sel_wr ? reg_wdata_in[RPSW_READ_PORT_BIT] : read_port_cur;

  // paged write steering per enabled port
  assign page_wr_en_next = page_wr ? wen_cur : 2'h0;

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      assign par_over[p] = par_cnt_reg[p] > parity_limit_setting_in;
      assign par_cnt_next[p] = par_clear[p] ? RPSW_PAR_CNT_RESET :
        ((parity_err_in[p] && par_cnt_reg[p] != RPSW_PAR_CNT_MAX) ?
         16'(par_cnt_reg[p] + 16'h0001) : par_cnt_reg[p]);
      rpsw_event_flag u_crc (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .set_in(crc_err_in[p]),
        .clear_in(sts_clear[p]),
        .flag_out(crc_flag[p])
      );
      rpsw_event_flag u_seq (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .set_in(seq_err_in[p]),
        .clear_in(sts_clear[p]),
        .flag_out(seq_flag[p])
      );
      rpsw_event_flag u_lchg (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .set_in(lock_change[p]),
        .clear_in(sts_clear[p]),
        .flag_out(lchg_flag[p])
      );
      rpsw_event_flag u_par (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .set_in(par_over[p] & ~par_clear[p]),
        .clear_in(par_clear[p]),
        .flag_out(par_flag[p])
      );
    end
  endgenerate

  // readback mux, paged registers follow read port
  wire rp = read_port_cur;
  wire [7:0] sel_byte = {1'b0, phys_port, 1'b0, read_port_cur, 2'h0, wen_cur};
  wire [7:0] sts_byte = {1'b0, rp, crc_flag[rp], lchg_flag[rp], seq_flag[rp],
                         par_flag[rp], pass_in[rp], lock_in[rp]};
  assign rd_data_next = !reg_rd_in ? rd_data_reg :
    (reg_addr_in == RPSW_PORT_SEL_ADDR) ? sel_byte :
    (reg_addr_in == RPSW_STATUS_A_ADDR) ? sts_byte :
    (reg_addr_in == RPSW_PAR_HI_ADDR) ? par_cnt_reg[rp][15:8] :
    (reg_addr_in == RPSW_PAR_LO_ADDR) ? par_cnt_reg[rp][7:0] : RPSW_DATA_RESET;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      src_reg <= RPSW_SRC_LOCAL;
      wen_reg <= RPSW_WEN_RESET;
      read_port_reg <= RPSW_READ_PORT_RESET;
      lock_prev_reg <= 2'h0;
    end else begin
      src_reg <= access ? src_now : src_reg;
      wen_reg <= wen_next;
      read_port_reg <= read_port_next;
      lock_prev_reg <= lock_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      par_cnt_reg[0] <= RPSW_PAR_CNT_RESET;
      par_cnt_reg[1] <= RPSW_PAR_CNT_RESET;
    end else begin
      par_cnt_reg[0] <= par_cnt_next[0];
      par_cnt_reg[1] <= par_cnt_next[1];
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_reg <= RPSW_DATA_RESET;
      rd_valid_reg <= 1'b0;
      page_wr_en_reg <= 2'h0;
      page_addr_reg <= RPSW_DATA_RESET;
      page_data_reg <= RPSW_DATA_RESET;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= reg_rd_in;
      page_wr_en_reg <= page_wr_en_next;
      page_addr_reg <= page_wr ? reg_addr_in : page_addr_reg;
      page_data_reg <= page_wr ? reg_wdata_in : page_data_reg;
    end
  end

  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign page_wr_en_out = page_wr_en_reg;
  assign page_addr_out = page_addr_reg;
  assign page_data_out = page_data_reg;
  assign read_port_out = read_port_reg;

  // checks
  port1_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    page_wr_en_out[1] |-> $past(wen_cur[1]) && $past(page_wr))
    else $error("port 1 paged write without its enable");
  port0_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    page_wr_en_out[0] |-> $past(wen_cur[0]) && $past(page_wr))
    else $error("port 0 paged write without its enable");
  dual_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (page_wr && wen_cur == 2'h3) |=> page_wr_en_out == 2'h3 && page_data_out == $past(reg_wdata_in))
    else $error("broadcast write did not reach both ports");
  remote_default_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (src_switch && !sel_wr && src_now == RPSW_SRC_REMOTE1) |=> wen_reg == 2'h2 && read_port_reg)
    else $error("remote port 1 defaults not loaded");
  status_port_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sts_rd |=> rd_data_out[RPSW_ST_PORT_BIT] == $past(read_port_cur))
    else $error("status port bit wrong");
  crc_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (sts_rd && !read_port_cur && !crc_err_in[0]) |=>
      !crc_flag[0] && rd_data_out[RPSW_ST_CRC_BIT] == $past(crc_flag[0]))
    else $error("checksum flag not cleared or reported by read");
  lock_change_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (lock_in[0] != lock_prev_reg[0]) |=> lchg_flag[0])
    else $error("lock change not latched");
  seq_latch_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    seq_err_in[1] |=> seq_flag[1])
    else $error("sequence error not latched");
  parity_flag_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (par_over[0] && !par_clear[0]) |=> par_flag[0])
    else $error("parity flag not set over limit");
  parity_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    par_clear[1] |=> !par_flag[1] && par_cnt_reg[1] == RPSW_PAR_CNT_RESET)
    else $error("parity flag not cleared with counter");
  live_bits_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (sts_rd && !read_port_cur) |=> rd_data_out[1:0] == {$past(pass_in[0]), $past(lock_in[0])})
    else $error("live pass or lock bit wrong");
  lo_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (par_lo_rd && read_port_cur) |=> par_cnt_reg[1] == RPSW_PAR_CNT_RESET)
    else $error("low byte read did not clear counter");

  // flag, counter and readback checks per port, plus source default and write steering checks
  crc_latch_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    crc_err_in[0] |=> crc_flag[0])
    else $error("port 0 checksum error not latched");
  crc1_latch_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    crc_err_in[1] |=> crc_flag[1])
    else $error("port 1 checksum error not latched");
  seq_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (sts_rd && !read_port_cur && !seq_err_in[0]) |=> !seq_flag[0])
    else $error("port 0 sequence flag not cleared by read");
  seq1_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (sts_rd && read_port_cur && !seq_err_in[1]) |=> !seq_flag[1])
    else $error("port 1 sequence flag not cleared by read");
  lchg_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (sts_rd && !read_port_cur && !lock_change[0]) |=> !lchg_flag[0])
    else $error("port 0 lock change flag not cleared by read");
  lchg1_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (sts_rd && read_port_cur && !lock_change[1]) |=> !lchg_flag[1])
    else $error("port 1 lock change flag not cleared by read");
  pass1_live_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (sts_rd && read_port_cur) |=> rd_data_out[RPSW_ST_PASS_BIT] == $past(pass_in[1]))
    else $error("port 1 live pass bit wrong");
  hi_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == RPSW_PAR_HI_ADDR && read_port_cur) |=>
      rd_data_out == $past(par_cnt_reg[1][15:8]))
    else $error("high byte read not from selected port");
  local_default_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (src_switch && !sel_wr && src_now == RPSW_SRC_LOCAL) |=>
      wen_reg == RPSW_WEN_RESET && !read_port_reg)
    else $error("local defaults not loaded");
  remote0_default_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (src_switch && !sel_wr && src_now == RPSW_SRC_REMOTE0) |=> wen_reg == 2'h1 && !read_port_reg)
    else $error("remote port 0 defaults not loaded");
  sel_no_page_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sel_wr |=> page_wr_en_out == 2'h0)
    else $error("port select write forwarded as paged write");
  parity_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (par_flag[0] && !par_clear[0]) |=> par_flag[0])
    else $error("parity flag dropped without counter clear");
  parity_below_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (!par_over[0] && !par_flag[0]) |=> !par_flag[0])
    else $error("parity flag set below limit");
  parity1_flag_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (par_over[1] && !par_clear[1]) |=> par_flag[1])
    else $error("port 1 parity flag not set over limit");
  count_step_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (parity_err_in[0] && !par_clear[0] && par_cnt_reg[0] != RPSW_PAR_CNT_MAX) |=>
      par_cnt_reg[0] == 16'($past(par_cnt_reg[0]) + 16'h0001))
    else $error("port 0 parity counter did not count");
  count1_step_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (parity_err_in[1] && !par_clear[1] && par_cnt_reg[1] != RPSW_PAR_CNT_MAX) |=>
      par_cnt_reg[1] == 16'($past(par_cnt_reg[1]) + 16'h0001))
    else $error("port 1 parity counter did not count");
  lock_rise_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    lock_valid_rise[0] |=> par_cnt_reg[0] == RPSW_PAR_CNT_RESET)
    else $error("lock rise did not clear counter");
  valid_pulse_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    reg_rd_in |=> rd_valid_out)
    else $error("read not answered");
  valid_idle_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !reg_rd_in |=> !rd_valid_out)
    else $error("read valid without request");
  page_addr_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    page_wr |=> page_addr_out == $past(reg_addr_in))
    else $error("paged write address not forwarded");
  status_msb_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sts_rd |=> !rd_data_out[7])
    else $error("status top bit not zero");
  unmapped_read_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == RPSW_STATUS_B_ADDR) |=> rd_data_out == RPSW_DATA_RESET)
    else $error("unmapped read not zero");
  read_port_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sel_wr |=> read_port_out == $past(reg_wdata_in[RPSW_READ_PORT_BIT]))
    else $error("read port select not stored");

  dual_write_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    page_wr_en_out == 2'h3);
  remote_switch_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    src_switch && src_now == RPSW_SRC_REMOTE0);
  race_clear_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    sts_rd && crc_err_in[0] && !read_port_cur);
  parity_over_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    par_flag[0] ##1 par_clear[0]);
  remote1_read_c: cover property (@(posedge ref_clk_in) disable iff (reset_in)
    sts_rd && read_port_cur);
endmodule

// >>> rpsw_rx_model.sv
`timescale 1ns/10ps
module rpsw_rx_model
  import rpsw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // paged write steering
  input wire logic [1:0] page_wr_en_in,
  input wire logic [7:0] page_addr_in,
  input wire logic [7:0] page_data_in,
  // last paged data per port
  output logic [7:0] port0_data_out,
  output logic [7:0] port1_data_out
);
  // one paged register per port, captured on its strobe
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      port0_data_out <= RPSW_DATA_RESET;
      port1_data_out <= RPSW_DATA_RESET;
    end else begin
      if (page_wr_en_in[0] && (page_addr_in !== 8'hXX)) begin
        port0_data_out <= page_data_in;
      end
      if (page_wr_en_in[1] && (page_addr_in !== 8'hXX)) begin
        port1_data_out <= page_data_in;
      end
    end
  end
endmodule

// >>> rx_port_status_write_select_tb.sv
`timescale 1ns/10ps
module rx_port_status_write_select_tb
  import rpsw_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic src_remote_in = 1'b0;
  logic src_port_in = 1'b0;
  logic [1:0] lock_in = 2'h0;
  logic [1:0] pass_in = 2'h0;
  logic [1:0] crc_err_in = 2'h0;
  logic [1:0] seq_err_in = 2'h0;
  logic [1:0] parity_err_in = 2'h0;
  logic [15:0] parity_limit_setting_in = 16'h0002;
  logic [7:0] rd_data_out;
  logic rd_valid_out;
  logic [1:0] page_wr_en_out;
  logic [7:0] page_addr_out;
  logic [7:0] page_data_out;
  logic read_port_out;
  logic [7:0] port0_data;
  logic [7:0] port1_data;
  int failures = 0;
  int num_checks = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  rpsw_reg_bank rpsw_reg_bank_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .src_remote_in(src_remote_in), .src_port_in(src_port_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .page_wr_en_out(page_wr_en_out),
    .page_addr_out(page_addr_out), .page_data_out(page_data_out),
    .read_port_out(read_port_out), .lock_in(lock_in), .pass_in(pass_in),
    .crc_err_in(crc_err_in), .seq_err_in(seq_err_in), .parity_err_in(parity_err_in),
    .parity_limit_setting_in(parity_limit_setting_in));

  rpsw_rx_model rpsw_rx_model_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .page_wr_en_in(page_wr_en_out), .page_addr_in(page_addr_out),
    .page_data_in(page_data_out), .port0_data_out(port0_data), .port1_data_out(port1_data));

  task automatic results;
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem,
                    input logic p, input logic [1:0] en);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    src_remote_in = rem;
    src_port_in = p;
    reg_wr_in = 1'b1;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
    chk("page_wr_en", {6'h00, en}, {6'h00, page_wr_en_out});
  endtask

  // crc pulses in the same cycle as the read request when asked
  task automatic rd(input logic [7:0] a, input logic rem, input logic p,
                    input logic crc, input logic [7:0] e);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    src_remote_in = rem;
    src_port_in = p;
    reg_rd_in = 1'b1;
    crc_err_in = {1'b0, crc};
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    crc_err_in = 2'h0;
    chk("rd_valid", 8'h01, {7'h00, rd_valid_out});
    chk("rd_data", e, rd_data_out);
  endtask

  // k bit 0 checksum, bit 1 sequence, bit 2 parity, port 0, n cycles
  task automatic pulse(input logic [2:0] k, input int n);
    @(negedge ref_clk_in);
    crc_err_in = {1'b0, k[0]};
    seq_err_in = {1'b0, k[1]};
    parity_err_in = {1'b0, k[2]};
    repeat (n) @(negedge ref_clk_in);
    crc_err_in = 2'h0;
    seq_err_in = 2'h0;
    parity_err_in = 2'h0;
  endtask

  initial begin
    #100us;
    failures++;
    results();
  end

  initial begin
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    reset_in = 1'b0;
    rd(RPSW_PORT_SEL_ADDR, 0, 0, 0, 8'h00);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h00);
    wr(8'h20, 8'hAA, 0, 0, 2'h0);
    wr(RPSW_PORT_SEL_ADDR, 8'h01, 0, 0, 2'h0);
    wr(8'h21, 8'h11, 0, 0, 2'h1);
    wr(RPSW_PORT_SEL_ADDR, 8'h02, 0, 0, 2'h0);
    wr(8'h22, 8'h22, 0, 0, 2'h2);
    wr(RPSW_PORT_SEL_ADDR, 8'h03, 0, 0, 2'h0);
    wr(8'h23, 8'h33, 0, 0, 2'h3);
    chk("page_addr", 8'h23, page_addr_out);
    chk("page_data", 8'h33, page_data_out);
    @(negedge ref_clk_in);
    chk("port0_data", 8'h33, port0_data);
    chk("port1_data", 8'h33, port1_data);
    rd(RPSW_PORT_SEL_ADDR, 1, 1, 0, 8'h52);
    wr(8'h30, 8'h5A, 1, 1, 2'h2);
    rd(RPSW_PORT_SEL_ADDR, 1, 0, 0, 8'h01);
    rd(RPSW_PORT_SEL_ADDR, 0, 0, 0, 8'h00);
    @(negedge ref_clk_in);
    chk("port1_data", 8'h5A, port1_data);
    chk("port0_data", 8'h33, port0_data);
    lock_in = 2'h1;
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h11);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h01);
    pass_in = 2'h1;
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h03);
    pulse(3'h1, 1);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 1, 8'h23);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h23);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h03);
    pulse(3'h2, 1);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h0B);
    pulse(3'h4, 1);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h03);
    pulse(3'h4, 2);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h07);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h07);
    rd(RPSW_PAR_HI_ADDR, 0, 0, 0, 8'h00);
    rd(RPSW_PAR_LO_ADDR, 0, 0, 0, 8'h03);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h03);
    wr(RPSW_PORT_SEL_ADDR, 8'h10, 0, 0, 2'h0);
    chk("read_port", 8'h01, {7'h00, read_port_out});
    rd(RPSW_PORT_SEL_ADDR, 0, 0, 0, 8'h10);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h40);
    @(negedge ref_clk_in);
    seq_err_in = 2'h2;
    @(negedge ref_clk_in);
    seq_err_in = 2'h0;
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h48);
    rd(RPSW_STATUS_A_ADDR, 0, 0, 0, 8'h40);
    rd(RPSW_PAR_LO_ADDR, 0, 0, 0, 8'h00);
    rd(RPSW_STATUS_B_ADDR, 0, 0, 0, 8'h00);
    results();
  end
endmodule
